//--- bench/pbmc_an_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbmc_an_model #(
  parameter int DLY = 6
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // negotiation handshake
  input wire logic an_restart_req,
  output var logic an_started
);
  logic [3:0] cnt;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      an_started <= 1'b0;
    end else begin
      an_started <= (cnt == DLY[3:0]);
      // once begun, a restart runs on even if the request is cleared
      // a new run starts only once the previous start pulse is gone
      if (cnt != 4'h0 || (an_restart_req && !an_started)) begin
        cnt <= (cnt == DLY[3:0]) ? 4'h0 : cnt + 4'h1;
      end
    end
  end
endmodule // pbmc_an_model
`default_nettype wire

//--- bench/pbmc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pbmc_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // register port
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_rdata,
  // mode
  input wire logic        core_reset,
  input wire logic        an_enable,
  input wire logic        speed_100,
  input wire logic        full_duplex,
  input wire logic        an_restart_req,
  input wire logic        an_started,
  input wire logic        isolate,
  input wire logic        mii_oe,
  // status
  input wire logic        link_fail_evt,
  input wire logic        status_rd,
  input wire logic        link_latched
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence rst_hold; core_reset [*8]; endsequence
  sequence rst_tail; ##24 core_reset ##1 !core_reset; endsequence
  soft_len_a: assert property ($rose(core_reset) |-> rst_hold ##1 rst_tail)
    else $error("soft reset length wrong");
  rst_read_a: assert property (core_reset && reg_rd && reg_addr == 5'h00 |=> reg_rdata[15])
    else $error("reset bit not seen during reset");
  rsvd_zero_a: assert property (reg_rd |=> reg_rdata[6:0] == 7'h00)
    else $error("reserved bits not zero");
  forced_ignore_a: assert property (an_enable |-> !speed_100 && !full_duplex)
    else $error("forced mode active with negotiation");
  restart_off_a: assert property (!an_enable && $past(!an_enable) |-> !an_restart_req)
    else $error("restart set while negotiation off");
  restart_clear_a: assert property (an_started && an_restart_req && !reg_wr |=> !an_restart_req)
    else $error("restart did not self clear");
  isolate_oe_a: assert property (isolate |=> !mii_oe)
    else $error("data outputs driven while isolated");
  latch_low_a: assert property (link_fail_evt ##1 !status_rd |=> !link_latched ##1 !link_latched)
    else $error("link latch not held low");
endmodule // pbmc_checker
bind pbmc_top pbmc_checker u_chk (.mclk, .rst_b, .reg_addr, .reg_rd, .reg_wr, .reg_rdata,
  .core_reset, .an_enable, .speed_100, .full_duplex, .an_restart_req, .an_started,
  .isolate, .mii_oe, .link_fail_evt, .status_rd, .link_latched);
`default_nettype wire

//--- bench/pbmc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbmc_consts.vh"
module pbmc_top_bench;
  logic        mclk, rst_b, reg_wr, reg_rd, tx_en, bit_tick, status_rd, rd_d, link_live;
  logic        strap_speed, strap_an_en, strap_duplex, line_rx_dv, line_col, fault_evt;
  logic        link_fail_evt, an_started, an_restart_req, speed_100, full_duplex, an_enable;
  logic        power_down, isolate, core_reset, rx_dv, col, mii_oe, link_latched, fault_latched;
  logic [1:0]  tk;
  logic [4:0]  reg_addr;
  logic [3:0]  txd, line_rxd, rxd;
  logic [15:0] reg_wdata, reg_rdata, w, exp_q[$], msk_q[$];
  int          err_total, compares, i;
  wire logic [15:0] sw = {2'h0, strap_speed, strap_an_en, 3'h0, strap_duplex, 8'h00};
  pbmc_top uut (.*);
  pbmc_an_model partner (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    tk <= tk + 2'h1;
    bit_tick <= (tk == 2'h3);
  end
  always @(posedge mclk) rd_d <= reg_rd;
  always @(negedge mclk) if (rd_d === 1'b1) check("rdata", msk_q.pop_front() & reg_rdata, exp_q.pop_front());
  task check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
    compares++;
    if (seen !== ex) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, ex, seen);
    end
  endtask
  task wr(input logic [15:0] d);
    reg_addr = 5'h00;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [15:0] ex, input logic [15:0] m);
    exp_q.push_back(ex & m);
    msk_q.push_back(m);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    report_and_stop;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, tx_en, status_rd, link_fail_evt, fault_evt, line_rx_dv} = 8'h00;
    {line_col, link_live, rd_d, bit_tick, tk, reg_addr, txd, line_rxd, reg_wdata} = 35'h0;
    err_total = 0;
    compares = 0;
    i = $urandom(49611);
    {strap_speed, strap_an_en, strap_duplex} = 3'($urandom);
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    rd(5'h00, sw, 16'hFFFF);
    rd(5'h05, 16'h0000, 16'hFFFF);
    $display("test reset done");
    repeat (3) begin
      w = (16'($urandom) & 16'h6FFF) | 16'h0200;
      wr(w);
      check("speed", speed_100, w[13]);
      check("duplex", full_duplex, w[8]);
      check("pdown", power_down, w[11]);
      check("restart", an_restart_req, 1'b0);
      rd(5'h00, w & 16'h6D80, 16'hFFFF);
    end
    wr(16'h3100);
    check("forced", {speed_100, full_duplex}, 2'h0);
    wr(16'h3300);
    wr(16'h3100);
    rd(5'h00, 16'h3300, 16'hFFFF);
    repeat (12) @(negedge mclk);
    rd(5'h00, 16'h3100, 16'hFFFF);
    $display("test autoneg done");
    wr(16'h4000);
    repeat (`PBMC_LOOP_SETTLE) @(negedge mclk);
    tx_en = 1'b1;
    txd = 4'($urandom);
    @(negedge mclk);
    check("rx_dv", rx_dv, 1'b1);
    check("rxd", rxd, txd);
    wr(16'h0000);
    line_rxd = ~txd;
    @(negedge mclk);
    check("rxd", rxd, line_rxd);
    tx_en = 1'b0;
    wr(16'h0400);
    @(negedge mclk);
    check("mii_oe", mii_oe, 1'b0);
    wr(16'h0000);
    @(negedge mclk);
    check("mii_oe", mii_oe, 1'b1);
    $display("test datapath done");
    wr(16'h0080);
    tx_en = 1'b1;
    for (i = 0; i < `PBMC_COL_ON_BITS * 4 && col !== 1'b1; i++) @(negedge mclk);
    check("col", col, 1'b1);
    tx_en = 1'b0;
    for (i = 0; i < `PBMC_COL_OFF_BITS * 4 && col !== 1'b0; i++) @(negedge mclk);
    check("col", col, 1'b0);
    $display("test collision done");
    link_live = 1'b1;
    status_rd = 1'b1;
    @(negedge mclk);
    {status_rd, link_fail_evt, fault_evt} = 3'h3;
    @(negedge mclk);
    {link_fail_evt, fault_evt} = 2'h0;
    repeat (3) @(negedge mclk);
    check("link", link_latched, 1'b0);
    check("fault", fault_latched, 1'b1);
    status_rd = 1'b1;
    @(negedge mclk);
    status_rd = 1'b0;
    @(negedge mclk);
    check("link", link_latched, 1'b1);
    check("fault", fault_latched, 1'b0);
    $display("test latch done");
    {strap_speed, strap_an_en, strap_duplex} = ~{strap_speed, strap_an_en, strap_duplex};
    wr(16'h8000);
    check("core_reset", core_reset, 1'b1);
    wr(16'h4000);
    for (i = 0; i < 60; i++) begin
      rd(5'h00, 16'h0000, 16'h0000);
      if (reg_rdata[15] === 1'b0) break;
    end
    rd(5'h00, sw, 16'hFFFF);
    $display("test soft reset done");
    report_and_stop;
  end
endmodule // pbmc_top_bench
`default_nettype wire

//--- include/pbmc_consts.vh
// Summary of operation
// - self-clearing field follows its live input, event unused
// - clear-on-read field unwritable, zeroed by read
// - latched-low holds zero until read returns it
// - latched-high holds one until read returns it
// - permanent read-only returns fixed value always
// - bit 15 soft reset, self-clears, re-samples straps
// - bit 14 loops transmit data onto receive
// - bit 13 forced speed, strap reset value
// - bit 12 auto-negotiation enable overrides speed, duplex
// - bit 8 forced duplex, strap reset value
// - bit 11 powers down all but registers and col in collision test, which still follows tx_en
// - bit 10 isolates port from data interface
// - bit 9 restart, self-clears, ignored when disabled
// - writing zero to restart leaves negotiation running
// - collision test asserts col within 512 bits
// - collision test drops col within 4 bits
// - bits 6:0 reserved, write ignored, read zero
`ifndef PBMC_CONSTS_VH
`define PBMC_CONSTS_VH
`define PBMC_ADDR_CTRL      5'h00
`define PBMC_BIT_RESET      15
`define PBMC_BIT_LOOPBACK   14
`define PBMC_BIT_SPEED      13
`define PBMC_BIT_AN_EN      12
`define PBMC_BIT_PWRDN      11
`define PBMC_BIT_ISOLATE    10
`define PBMC_BIT_AN_RESTART 9
`define PBMC_BIT_DUPLEX     8
`define PBMC_BIT_COL_TEST   7
`define PBMC_RSVD_MASK      16'h007F
`define PBMC_RST_CYCLES     8'h20
`define PBMC_COL_ON_BITS    512
`define PBMC_COL_OFF_BITS   4
`define PBMC_COL_DELAY      2'h2
`define PBMC_LOOP_SETTLE    4
`endif

//--- rtl/pbmc_field.v
`timescale 1ns/1ps
`default_nettype none
`include "pbmc_consts.vh"
// one status bit of a generic access type
module pbmc_field #(
  parameter [2:0] ftype    = 3'h0, // 0 sc, 1 cor, 2 ll, 3 lh, 4 permanent
  parameter       fixed_val = 1'b0
) (
  // clock and reset
  input  wire mclk,
  input  wire rst_b,
  input  wire soft_rst,
  // event side
  input  wire live,
  input  wire evt,
  // management read of this field
  input  wire rd_pulse,
  // value
  output reg  value
);
  reg held;
  reg next_value;
  reg next_held;

  always @* begin
    next_value = value;
    next_held  = held;
    case (ftype)
      3'h0: next_value = live;
      3'h1: next_value = evt | (value & ~rd_pulse);
      3'h2: begin
        if (evt) begin
          next_held = 1'b1;
        end else if (rd_pulse) begin
          next_held = 1'b0;
        end
        next_value = (held & ~rd_pulse) | evt ? 1'b0 : live;
      end
      3'h3: begin
        if (evt) begin
          next_held = 1'b1;
        end else if (rd_pulse) begin
          next_held = 1'b0;
        end
        next_value = ((held & ~rd_pulse) | evt) ? 1'b1 : live;
      end
      default: next_value = fixed_val;
    endcase
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      value <= (ftype == 3'h4) ? fixed_val : 1'b0;
      held  <= 1'b0;
    end else if (soft_rst) begin
      value <= (ftype == 3'h4) ? fixed_val : 1'b0;
      held  <= 1'b0;
    end else begin
      value <= next_value;
      held  <= next_held;
    end
  end
endmodule // pbmc_field
`default_nettype wire

//--- rtl/pbmc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pbmc_consts.vh"
module pbmc_top (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_b,
  // strap pins
  input  wire        strap_speed,
  input  wire        strap_an_en,
  input  wire        strap_duplex,
  // management register port
  input  wire [4:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  // auto-negotiation engine
  input  wire        an_started,
  output wire        an_restart_req,
  // operating mode
  output wire        speed_100,
  output wire        full_duplex,
  output wire        an_enable,
  output wire        power_down,
  output wire        isolate,
  output wire        core_reset,
  // bit-time enable for collision test
  input  wire        bit_tick,
  // mii data path
  input  wire        tx_en,
  input  wire [3:0]  txd,
  input  wire        line_rx_dv,
  input  wire [3:0]  line_rxd,
  input  wire        line_col,
  output reg         rx_dv,
  output reg  [3:0]  rxd,
  output reg         col,
  output reg         mii_oe,
  // example latched status fields
  input  wire        link_live,
  input  wire        link_fail_evt,
  input  wire        fault_evt,
  output wire        link_latched,
  output wire        fault_latched,
  input  wire        status_rd
);
  reg        sw_rst;
  reg [7:0]  rst_cnt;
  reg        strap_pend;
  reg        loopback;
  reg        speed;
  reg        an_en;
  reg        pwrdn;
  reg        iso;
  reg        an_restart;
  reg        duplex;
  reg        col_test;
  reg [1:0]  col_cnt;
  reg        next_col;
  wire       ctrl_hit;
  wire [15:0] ctrl_val;

  assign ctrl_hit = (reg_addr == `PBMC_ADDR_CTRL);
  assign ctrl_val = {sw_rst, loopback, speed, an_en, pwrdn, iso, an_restart,
                     duplex, col_test, 7'h00};

  // strap capture after hard reset release and at soft reset end
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strap_pend <= 1'b1;
      sw_rst     <= 1'b0;
      rst_cnt    <= 8'h00;
      loopback   <= 1'b0;
      speed      <= 1'b0;
      an_en      <= 1'b0;
      pwrdn      <= 1'b0;
      iso        <= 1'b0;
      an_restart <= 1'b0;
      duplex     <= 1'b0;
      col_test   <= 1'b0;
    end else if (strap_pend) begin
      strap_pend <= 1'b0;
      speed      <= strap_speed;
      an_en      <= strap_an_en;
      duplex     <= strap_duplex;
    end else if (sw_rst) begin
      if (rst_cnt == `PBMC_RST_CYCLES) begin
        sw_rst     <= 1'b0;
        strap_pend <= 1'b1;
        rst_cnt    <= 8'h00;
      end else begin
        rst_cnt <= rst_cnt + 8'h01;
      end
      loopback   <= 1'b0;
      pwrdn      <= 1'b0;
      iso        <= 1'b0;
      an_restart <= 1'b0;
      col_test   <= 1'b0;
    end else if (reg_wr && ctrl_hit) begin
      sw_rst   <= reg_wdata[`PBMC_BIT_RESET];
      loopback <= reg_wdata[`PBMC_BIT_LOOPBACK];
      speed    <= reg_wdata[`PBMC_BIT_SPEED];
      an_en    <= reg_wdata[`PBMC_BIT_AN_EN];
      pwrdn    <= reg_wdata[`PBMC_BIT_PWRDN];
      iso      <= reg_wdata[`PBMC_BIT_ISOLATE];
      duplex   <= reg_wdata[`PBMC_BIT_DUPLEX];
      col_test <= reg_wdata[`PBMC_BIT_COL_TEST];
      // zero written to restart with AN_EN set clears a pending restart only if an_started is high
      if (reg_wdata[`PBMC_BIT_AN_RESTART] && reg_wdata[`PBMC_BIT_AN_EN]) begin
        an_restart <= 1'b1;
      end else if (an_started || !reg_wdata[`PBMC_BIT_AN_EN]) begin
        an_restart <= 1'b0;
      end
    end else if (an_started || !an_en) begin
      an_restart <= 1'b0;
    end
  end

  assign an_restart_req = an_restart;
  assign an_enable      = an_en;
  assign speed_100      = an_en ? 1'b0 : speed;
  assign full_duplex    = an_en ? 1'b0 : duplex;
  assign power_down     = pwrdn;
  assign isolate        = iso;
  assign core_reset     = sw_rst;

  // read data
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= ctrl_hit ? ctrl_val : 16'h0000;
    end
  end

  // collision test: col follows tx_en, drops within a few bit times
  always @* begin
    next_col = col;
    if (col_test) begin
      if (tx_en) begin
        next_col = 1'b1;
      end else if (col_cnt == `PBMC_COL_DELAY) begin
        next_col = 1'b0;
      end
    end else begin
      next_col = line_col & ~pwrdn;
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      col     <= 1'b0;
      col_cnt <= 2'h0;
    end else begin
      col <= next_col;
      if (tx_en || !col) begin
        col_cnt <= 2'h0;
      end else if (bit_tick && col_cnt != `PBMC_COL_DELAY) begin
        col_cnt <= col_cnt + 2'h1;
      end
    end
  end

  // receive path, loopback and isolation
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_dv  <= 1'b0;
      rxd    <= 4'h0;
      mii_oe <= 1'b0;
    end else begin
      mii_oe <= ~iso & ~pwrdn;
      if (iso || pwrdn) begin
        rx_dv <= 1'b0;
        rxd   <= 4'h0;
      end else if (loopback) begin
        rx_dv <= tx_en;
        rxd   <= txd;
      end else begin
        rx_dv <= line_rx_dv;
        rxd   <= line_rxd;
      end
    end
  end

  // example status fields using the generic access types
  pbmc_field #(.ftype(3'h2), .fixed_val(1'b0)) u_link (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .soft_rst (sw_rst),
    .live     (link_live),
    .evt      (link_fail_evt),
    .rd_pulse (status_rd),
    .value    (link_latched)
  );

  pbmc_field #(.ftype(3'h3), .fixed_val(1'b0)) u_fault (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .soft_rst (sw_rst),
    .live     (1'b0),
    .evt      (fault_evt),
    .rd_pulse (status_rd),
    .value    (fault_latched)
  );
endmodule // pbmc_top
`default_nettype wire
